// [tcc_timer16_regs.svh]
// Constants for the 16-bit capture/compare timer
`ifndef TCC_TIMER16_REGS_SVH
`define TCC_TIMER16_REGS_SVH

// Counter and compare values
`define TCC_CNT_RELOAD     16'hFFFC
`define TCC_CNT_MAX        16'hFFFF
`define TCC_CMP_RESET      16'h8000

// Clock select field encodings
`define TCC_CLK_DIV4       2'h0
`define TCC_CLK_DIV2       2'h1
`define TCC_CLK_DIV8       2'h2
`define TCC_CLK_EXT        2'h3

// Prescaler masks (divide minus one)
`define TCC_MASK_DIV2      3'h1
`define TCC_MASK_DIV4      3'h3
`define TCC_MASK_DIV8      3'h7

// Status byte bit positions
`define TCC_SR_CAPF1_BIT   7
`define TCC_SR_CMPF1_BIT   6
`define TCC_SR_OVF_BIT     5
`define TCC_SR_CAPF2_BIT   4
`define TCC_SR_CMPF2_BIT   3

// Least CPU clocks between two active external clock edges
`define TCC_EXT_MIN_GAP    4

`endif

// [tcc_pkg.sv]
// Types shared by the timer modules
package tcc_pkg;

  typedef enum logic [3:0] {
    ACC_NONE,
    ACC_CNT_HI,
    ACC_CNT_LO,
    ACC_ALT_HI,
    ACC_ALT_LO,
    ACC_STATUS,
    ACC_CAP1_HI,
    ACC_CAP1_LO,
    ACC_CAP2_HI,
    ACC_CAP2_LO,
    ACC_CMP1_HI,
    ACC_CMP1_LO,
    ACC_CMP2_HI,
    ACC_CMP2_LO
  } tcc_acc_e;

  typedef logic [15:0] tcc_count_t;

endpackage

// [tcc_tick.sv]
// Timer clock generator: prescaler and external clock edge detect
`timescale 1ns/1ps
`default_nettype none
`include "tcc_timer16_regs.svh"

module tcc_tick (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // Configuration
  input  wire logic [1:0] i_clock_select_field,
  input  wire logic       i_ext_clock_edge_select,
  input  wire logic       i_halt,
  // Pin
  input  wire logic       i_ext_clock_pin,
  // Timer clock
  output logic            o_tick,
  output logic            o_div2
);
  import tcc_pkg::*;

  logic [2:0] pre_reg;
  logic [2:0] pre_next;
  logic       ext_prev_reg;
  logic       ext_prev_next;
  logic       tick_reg;
  logic       tick_next;
  logic [2:0] mask;
  logic       ext_sel;
  logic       ext_edge;
  logic       ext_prime_reg;

  always_comb begin
    ext_sel = (i_clock_select_field == `TCC_CLK_EXT);
    unique case (i_clock_select_field)
      `TCC_CLK_DIV2: mask = `TCC_MASK_DIV2;
      `TCC_CLK_DIV8: mask = `TCC_MASK_DIV8;
      default:       mask = `TCC_MASK_DIV4;
    endcase
    // Edge picked by polarity control; pin sampled once per CPU clock
    // The first sample after reset only primes the detector, so a pin resting high is not an edge
    ext_edge = (i_ext_clock_pin != ext_prev_reg) && (i_ext_clock_pin == i_ext_clock_edge_select)
               && ext_prime_reg;
    ext_prev_next = i_ext_clock_pin;
    pre_next = pre_reg;
    tick_next = 1'b0;
    // Halt freezes the prescaler so counting resumes from the held value
    if (!i_halt) begin
      if (ext_sel) begin
        tick_next = ext_edge;
      end else begin
        pre_next = pre_reg + 3'h1;
        tick_next = ((pre_reg & mask) == mask);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pre_reg <= 3'h0;
      ext_prev_reg <= 1'b0;
      ext_prime_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else if (i_ce) begin
      pre_reg <= pre_next;
      ext_prev_reg <= ext_prev_next;
      ext_prime_reg <= 1'b1;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg & i_ce;
  assign o_div2 = (i_clock_select_field == `TCC_CLK_DIV2);

  property p_halt_no_tick;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && i_halt |=> !tick_reg;
  endproperty
  a_halt_no_tick: assert property (p_halt_no_tick) else $error("tick while halted");

  property p_ext_edge;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && ext_sel && !i_halt && ext_edge |=> tick_reg;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external edge lost");
endmodule
`default_nettype wire

// [tcc_timer16.sv]
// 16-bit free-running timer with two captures and two compares
// Behaviour
// - High byte read first latches low byte; stays frozen until low byte read.
// - After a completed pair, a lone low-byte read returns the live count.
// - Counter wrapping FFFF to 0000 sets the overflow flag in any mode.
// - Overflow interrupt needs its enable set and the CPU mask clear.
// - Overflow clears after status read seeing it, then main low-byte access.
// - Alternate low-byte access never clears the overflow flag.
// - Counter runs in wait, stops in halt, resumes from held value.
// - Clock select field 11 picks the external clock input.
// - Edge-select bit chooses rising or falling external clock edges.
// - External edges synchronised to CPU clock; source keeps four clocks apart.
// - Active capture edge copies counter to capture register, sets capture flag.
// - Capture interrupt needs shared enable set and CPU mask clear.
// - Capture flag clears after status read, then that channel low-byte access.
// - Capture high-byte read blocks new captures until low byte read.
// - In one-pulse and PWM modes only capture channel 2 works.
// - Counter matching compare value sets compare flag and may interrupt.
// - Compare registers only change by software; reset loads 8000h.
// - With pin enable, match drives pin to level bit; pin low in reset.
// - Compare flag clears after status read, then that channel low-byte access.
// - Compare high-byte write suspends comparing until low byte written.
// - Divide-by-2 matches at equal count; other clocks at count plus one.
// - Force bit copies level to pin, no flag; ignored in one-pulse/PWM.
// - Reset and any counter low-byte write load FFFCh.
// - Internal timer clock is CPU clock divided by 2, 4 or 8.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_timer16_regs.svh"

module tcc_timer16 (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // Byte access port
  input  wire tcc_pkg::tcc_acc_e i_acc_sel,
  input  wire logic             i_acc_rd,
  input  wire logic             i_acc_wr,
  input  wire logic [7:0]       i_acc_wdata,
  output logic [7:0]            o_acc_rdata,
  // Configuration
  input  wire logic [1:0]       i_clock_select_field,
  input  wire logic             i_ext_clock_edge_select,
  input  wire logic [1:0]       i_capture_edge_select,
  input  wire logic [1:0]       i_compare_pin_enable,
  input  wire logic [1:0]       i_compare_output_level,
  input  wire logic [1:0]       i_force_output_level,
  input  wire logic             i_single_pulse_mode,
  input  wire logic             i_pwm_mode,
  input  wire logic             i_overflow_irq_enable,
  input  wire logic             i_capture_irq_enable,
  input  wire logic             i_compare_irq_enable,
  input  wire logic             i_cpu_irq_mask,
  input  wire logic             i_halt,
  // Pins
  input  wire logic             i_ext_clock_pin,
  input  wire logic [1:0]       i_capture_input_pin,
  output logic [1:0]            o_compare_output_pin,
  output logic [1:0]            o_compare_output_oe,
  // Status
  output logic                  o_overflow_flag,
  output logic [1:0]            o_capture_flag,
  output logic [1:0]            o_compare_flag,
  output logic                  o_irq
);
  import tcc_pkg::*;

  localparam tcc_acc_e CAP_HI [2] = '{ACC_CAP1_HI, ACC_CAP2_HI};
  localparam tcc_acc_e CAP_LO [2] = '{ACC_CAP1_LO, ACC_CAP2_LO};
  localparam tcc_acc_e CMP_HI [2] = '{ACC_CMP1_HI, ACC_CMP2_HI};
  localparam tcc_acc_e CMP_LO [2] = '{ACC_CMP1_LO, ACC_CMP2_LO};
  localparam tcc_acc_e VIEW_HI [2] = '{ACC_CNT_HI, ACC_ALT_HI};
  localparam tcc_acc_e VIEW_LO [2] = '{ACC_CNT_LO, ACC_ALT_LO};

  function automatic logic acc_is(input tcc_acc_e sel, input tcc_acc_e code, input logic strobe);
    acc_is = strobe && (sel == code);
  endfunction

  logic        tick;
  logic        div2;
  logic        acc;
  logic        st_rd;
  logic        special;
  tcc_count_t  cnt_reg;
  tcc_count_t  cnt_next;
  logic        tick_d_reg;
  logic [7:0]  lo_buf_reg [2];
  logic [7:0]  lo_buf_next [2];
  logic [1:0]  lock_reg;
  logic [1:0]  lock_next;
  logic        ovf_reg;
  logic        ovf_next;
  logic        ovf_arm_reg;
  logic        ovf_arm_next;
  logic        ovf_clr;
  tcc_count_t  cap_val_reg [2];
  tcc_count_t  cap_val_next [2];
  logic [1:0]  capf_reg;
  logic [1:0]  capf_next;
  logic [1:0]  cap_arm_reg;
  logic [1:0]  cap_arm_next;
  logic [1:0]  cap_block_reg;
  logic [1:0]  cap_block_next;
  logic [1:0]  cap_prev_reg;
  logic        prime_reg;
  logic [1:0]  cap_evt;
  logic [1:0]  cap_clr;
  tcc_count_t  cmp_val_reg [2];
  tcc_count_t  cmp_val_next [2];
  logic [1:0]  cmpf_reg;
  logic [1:0]  cmpf_next;
  logic [1:0]  cmp_arm_reg;
  logic [1:0]  cmp_arm_next;
  logic [1:0]  cmp_inh_reg;
  logic [1:0]  cmp_inh_next;
  logic [1:0]  cmp_match;
  logic [1:0]  cmp_clr;
  logic [1:0]  pin_reg;
  logic [1:0]  pin_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [7:0]  mux;

  tcc_tick u_tick (
    .i_ref_clk               (i_ref_clk),
    .i_rst                   (i_rst),
    .i_ce                    (i_ce),
    .i_clock_select_field    (i_clock_select_field),
    .i_ext_clock_edge_select (i_ext_clock_edge_select),
    .i_halt                  (i_halt),
    .i_ext_clock_pin         (i_ext_clock_pin),
    .o_tick                  (tick),
    .o_div2                  (div2)
  );

  always_comb begin
    acc = i_acc_rd | i_acc_wr;
    st_rd = acc_is(i_acc_sel, ACC_STATUS, i_acc_rd);
    special = i_single_pulse_mode | i_pwm_mode;

    // Counter and overflow
    cnt_next = tick ? cnt_reg + 16'h0001 : cnt_reg;
    if (acc_is(i_acc_sel, ACC_CNT_LO, i_acc_wr) || acc_is(i_acc_sel, ACC_ALT_LO, i_acc_wr)) begin
      cnt_next = `TCC_CNT_RELOAD;
    end
    // Only the main low byte completes the clear; alternate view is harmless
    ovf_clr = ovf_arm_reg && acc_is(i_acc_sel, ACC_CNT_LO, acc);
    ovf_next = (tick && cnt_reg == `TCC_CNT_MAX) || (ovf_reg && !ovf_clr);
    ovf_arm_next = (ovf_arm_reg && !ovf_clr) || (st_rd && ovf_reg);

    for (int v = 0; v < 2; v++) begin
      lo_buf_next[v] = lo_buf_reg[v];
      lock_next[v] = lock_reg[v];
      // Repeated high reads keep the first snapshot
      if (acc_is(i_acc_sel, VIEW_HI[v], i_acc_rd) && !lock_reg[v]) begin
        lo_buf_next[v] = cnt_reg[7:0];
        lock_next[v] = 1'b1;
      end
      if (acc_is(i_acc_sel, VIEW_LO[v], i_acc_rd)) begin
        lock_next[v] = 1'b0;
      end
    end

    for (int c = 0; c < 2; c++) begin
      // Channel 1 is claimed by the pulse generators in special modes;
      // no edge until one sample after reset, or a pin resting high would capture
      cap_evt[c] = (i_capture_input_pin[c] != cap_prev_reg[c]) && (i_capture_input_pin[c] == i_capture_edge_select[c])
                   && prime_reg && !cap_block_reg[c] && (!special || c == 1);
      cap_val_next[c] = cap_evt[c] ? cnt_reg : cap_val_reg[c];
      cap_clr[c] = cap_arm_reg[c] && acc_is(i_acc_sel, CAP_LO[c], acc);
      capf_next[c] = cap_evt[c] || (capf_reg[c] && !cap_clr[c]);
      cap_arm_next[c] = (cap_arm_reg[c] && !cap_clr[c]) || (st_rd && capf_reg[c]);
      cap_block_next[c] = cap_block_reg[c];
      if (acc_is(i_acc_sel, CAP_HI[c], i_acc_rd)) begin
        cap_block_next[c] = 1'b1;
      end
      if (acc_is(i_acc_sel, CAP_LO[c], i_acc_rd)) begin
        cap_block_next[c] = 1'b0;
      end

      // Slower clocks see the match one count late, as the counter is sampled after the tick
      cmp_match[c] = tick_d_reg && !cmp_inh_reg[c]
                     && (cnt_reg == (div2 ? cmp_val_reg[c] : cmp_val_reg[c] + 16'h0001));
      cmp_val_next[c] = cmp_val_reg[c];
      cmp_inh_next[c] = cmp_inh_reg[c];
      if (acc_is(i_acc_sel, CMP_HI[c], i_acc_wr)) begin
        cmp_val_next[c][15:8] = i_acc_wdata;
        cmp_inh_next[c] = 1'b1;
      end
      if (acc_is(i_acc_sel, CMP_LO[c], i_acc_wr)) begin
        cmp_val_next[c][7:0] = i_acc_wdata;
        cmp_inh_next[c] = 1'b0;
      end
      cmp_clr[c] = cmp_arm_reg[c] && acc_is(i_acc_sel, CMP_LO[c], acc);
      cmpf_next[c] = cmp_match[c] || (cmpf_reg[c] && !cmp_clr[c]);
      cmp_arm_next[c] = (cmp_arm_reg[c] && !cmp_clr[c]) || (st_rd && cmpf_reg[c]);
      pin_next[c] = pin_reg[c];
      if ((cmp_match[c] && i_compare_pin_enable[c]) || (i_force_output_level[c] && !special)) begin
        pin_next[c] = i_compare_output_level[c];
      end
    end

    unique case (i_acc_sel)
      ACC_CNT_HI:  mux = cnt_reg[15:8];
      ACC_ALT_HI:  mux = cnt_reg[15:8];
      ACC_CNT_LO:  mux = lock_reg[0] ? lo_buf_reg[0] : cnt_reg[7:0];
      ACC_ALT_LO:  mux = lock_reg[1] ? lo_buf_reg[1] : cnt_reg[7:0];
      ACC_CAP1_HI: mux = cap_val_reg[0][15:8];
      ACC_CAP1_LO: mux = cap_val_reg[0][7:0];
      ACC_CAP2_HI: mux = cap_val_reg[1][15:8];
      ACC_CAP2_LO: mux = cap_val_reg[1][7:0];
      ACC_CMP1_HI: mux = cmp_val_reg[0][15:8];
      ACC_CMP1_LO: mux = cmp_val_reg[0][7:0];
      ACC_CMP2_HI: mux = cmp_val_reg[1][15:8];
      ACC_CMP2_LO: mux = cmp_val_reg[1][7:0];
      ACC_STATUS: begin
        mux = 8'h00;
        mux[`TCC_SR_CAPF1_BIT] = capf_reg[0];
        mux[`TCC_SR_CMPF1_BIT] = cmpf_reg[0];
        mux[`TCC_SR_OVF_BIT] = ovf_reg;
        mux[`TCC_SR_CAPF2_BIT] = capf_reg[1];
        mux[`TCC_SR_CMPF2_BIT] = cmpf_reg[1];
      end
      default:     mux = 8'h00;
    endcase
    rdata_next = i_acc_rd ? mux : rdata_reg;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_reg <= `TCC_CNT_RELOAD;
      tick_d_reg <= 1'b0;
      lock_reg <= 2'h0;
      ovf_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
      capf_reg <= 2'h0;
      cap_arm_reg <= 2'h0;
      cap_block_reg <= 2'h0;
      cap_prev_reg <= 2'h0;
      prime_reg <= 1'b0;
      cmpf_reg <= 2'h0;
      cmp_arm_reg <= 2'h0;
      cmp_inh_reg <= 2'h0;
      pin_reg <= 2'h0;
      rdata_reg <= 8'h00;
      for (int c = 0; c < 2; c++) begin
        lo_buf_reg[c] <= 8'h00;
        cap_val_reg[c] <= 16'h0000;
        cmp_val_reg[c] <= `TCC_CMP_RESET;
      end
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
      tick_d_reg <= tick;
      lock_reg <= lock_next;
      ovf_reg <= ovf_next;
      ovf_arm_reg <= ovf_arm_next;
      capf_reg <= capf_next;
      cap_arm_reg <= cap_arm_next;
      cap_block_reg <= cap_block_next;
      cap_prev_reg <= i_capture_input_pin;
      prime_reg <= 1'b1;
      cmpf_reg <= cmpf_next;
      cmp_arm_reg <= cmp_arm_next;
      cmp_inh_reg <= cmp_inh_next;
      pin_reg <= pin_next;
      rdata_reg <= rdata_next;
      for (int c = 0; c < 2; c++) begin
        lo_buf_reg[c] <= lo_buf_next[c];
        cap_val_reg[c] <= cap_val_next[c];
        cmp_val_reg[c] <= cmp_val_next[c];
      end
    end
  end

  assign o_acc_rdata = rdata_reg;
  assign o_compare_output_pin = pin_reg;
  // Without pin enable the pin belongs to the port logic
  assign o_compare_output_oe = i_compare_pin_enable;
  assign o_overflow_flag = ovf_reg;
  assign o_capture_flag = capf_reg;
  assign o_compare_flag = cmpf_reg;
  // Pending flags wait here until the CPU mask opens
  assign o_irq = !i_cpu_irq_mask && ((ovf_reg && i_overflow_irq_enable) || (|capf_reg && i_capture_irq_enable)
                 || (|cmpf_reg && i_compare_irq_enable));

  property p_ovf_set;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && tick && !i_acc_wr && cnt_reg == 16'hFFFF |=> ovf_reg && cnt_reg == 16'h0000;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

  property p_reload;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && i_acc_wr && (i_acc_sel == ACC_CNT_LO || i_acc_sel == ACC_ALT_LO) |=> cnt_reg == 16'hFFFC;
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");

  property p_ovf_needs_arm;
    @(posedge i_ref_clk) disable iff (i_rst)
      ovf_reg && !ovf_arm_reg |=> ovf_reg;
  endproperty
  a_ovf_needs_arm: assert property (p_ovf_needs_arm) else $error("overflow cleared without status read");

  property p_alt_keeps_ovf;
    @(posedge i_ref_clk) disable iff (i_rst)
      ovf_reg && (i_acc_rd || i_acc_wr) && i_acc_sel == ACC_ALT_LO |=> ovf_reg;
  endproperty
  a_alt_keeps_ovf: assert property (p_alt_keeps_ovf) else $error("alternate view cleared overflow");

  property p_irq_mask;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_cpu_irq_mask |-> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt through mask");

  property p_cap_copy;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && cap_evt[1] |=> capf_reg[1] && cap_val_reg[1] == $past(cnt_reg);
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture value wrong");

  property p_cap_block;
    @(posedge i_ref_clk) disable iff (i_rst)
      cap_block_reg[0] |=> $stable(cap_val_reg[0]);
  endproperty
  a_cap_block: assert property (p_cap_block) else $error("capture while blocked");

  property p_cap1_special;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_single_pulse_mode || i_pwm_mode) |-> !cap_evt[0];
  endproperty
  a_cap1_special: assert property (p_cap1_special) else $error("channel 1 captured in special mode");

  property p_cmp_inhibit;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && i_acc_wr && i_acc_sel == ACC_CMP1_HI |=> !cmp_match[0];
  endproperty
  a_cmp_inhibit: assert property (p_cmp_inhibit) else $error("compare after high write");

  property p_cmp_pin;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && cmp_match[0] && i_compare_pin_enable[0] && !i_force_output_level[0]
        |=> cmpf_reg[0] && pin_reg[0] == $past(i_compare_output_level[0]);
  endproperty
  a_cmp_pin: assert property (p_cmp_pin) else $error("compare match not applied");

  property p_force;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && i_force_output_level[0] && !i_single_pulse_mode && !i_pwm_mode && !cmp_match[0] && !cmpf_reg[0]
        |=> !cmpf_reg[0] && pin_reg[0] == $past(i_compare_output_level[0]);
  endproperty
  a_force: assert property (p_force) else $error("force output wrong");
endmodule
`default_nettype wire

// [tcc_pin_model.sv]
// Far-side model of the timer pins: external clock source and capture inputs
`timescale 1ns/1ps
`default_nettype none
`include "tcc_timer16_regs.svh"

module tcc_pin_model (
  // Clock
  input  wire logic     i_ref_clk,
  // Pins toward the timer
  output var logic       o_ext_clock_pin,
  output var logic [1:0] o_capture_input_pin
);
  initial begin
    o_ext_clock_pin     = 1'b0;
    o_capture_input_pin = 2'h0;
  end

  // One transition, then hold so the next edge keeps the minimum spacing
  task automatic ext_toggle();
    @(negedge i_ref_clk);
    o_ext_clock_pin = ~o_ext_clock_pin;
    repeat (`TCC_EXT_MIN_GAP + 2) @(negedge i_ref_clk);
  endtask

  // Hold time covers the pin sample and the copy into the capture register
  task automatic cap_set(input int ch, input logic val);
    @(negedge i_ref_clk);
    o_capture_input_pin[ch] = val;
    repeat (3) @(negedge i_ref_clk);
  endtask
endmodule

`default_nettype wire

// [tcc_timer16_tb.sv]
// Self-checking bench for the 16-bit capture/compare timer
`timescale 1ns/1ps
`default_nettype none
`include "tcc_timer16_regs.svh"

module tcc_timer16_tb;
  import tcc_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  tcc_acc_e    sel = ACC_NONE;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic [1:0]  clk_sel = `TCC_CLK_DIV4;
  logic        ext_edge = 1'b1;
  logic [1:0]  cap_edge = 2'h1;
  logic [1:0]  pin_en = 2'h1;
  logic [1:0]  lvl = 2'h0;
  logic [1:0]  frc = 2'h0;
  logic        single_pulse_mode = 1'b0;
  logic        pwm = 1'b0;
  logic        ovf_ie = 1'b0;
  logic        cap_ie = 1'b0;
  logic        cmp_ie = 1'b0;
  logic        mask = 1'b0;
  logic        halt = 1'b1;
  logic        ext_pin;
  logic [1:0]  cap_pin;
  logic [1:0]  cmp_pin;
  logic [1:0]  cmp_oe;
  logic        ovf;
  logic [1:0]  cap_flag;
  logic [1:0]  cmp_flag;
  logic        irq;
  int          miscompares = 0;
  int          comparisons = 0;
  logic [7:0]  b;
  logic [15:0] v;
  logic [15:0] w;
  int          t_ovf;
  int          t_cmp;
  logic [1:0]  codes [4] = '{`TCC_CLK_DIV2, `TCC_CLK_DIV4, `TCC_CLK_DIV8, `TCC_CLK_DIV2};
  int          divs  [4] = '{2, 4, 8, 2};
  logic [1:0]  c_code [4] = '{`TCC_CLK_DIV2, `TCC_CLK_DIV2, `TCC_CLK_DIV4, `TCC_CLK_DIV8};
  logic [15:0] c_val  [4] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000};
  int          c_off  [4] = '{-1, 1, 1, 9};
  logic        e_sel  [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  int          e_inc  [4] = '{1, 0, 0, 1};

  always #20 clk = ~clk;

  tcc_pin_model pins (.i_ref_clk(clk), .o_ext_clock_pin(ext_pin), .o_capture_input_pin(cap_pin));

  tcc_timer16 dut (
    .i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1),
    .i_acc_sel(sel), .i_acc_rd(rd), .i_acc_wr(wr), .i_acc_wdata(wdata), .o_acc_rdata(rdata),
    .i_clock_select_field(clk_sel), .i_ext_clock_edge_select(ext_edge), .i_capture_edge_select(cap_edge),
    .i_compare_pin_enable(pin_en), .i_compare_output_level(lvl), .i_force_output_level(frc),
    .i_single_pulse_mode(single_pulse_mode), .i_pwm_mode(pwm), .i_overflow_irq_enable(ovf_ie),
    .i_capture_irq_enable(cap_ie), .i_compare_irq_enable(cmp_ie), .i_cpu_irq_mask(mask), .i_halt(halt),
    .i_ext_clock_pin(ext_pin), .i_capture_input_pin(cap_pin), .o_compare_output_pin(cmp_pin),
    .o_compare_output_oe(cmp_oe), .o_overflow_flag(ovf), .o_capture_flag(cap_flag),
    .o_compare_flag(cmp_flag), .o_irq(irq)
  );

  task automatic summarize();
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic fail(input string msg);
    miscompares++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) fail($sformatf("bit got %b exp %b", got, exp));
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("byte got %h exp %h", got, exp));
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("word got %h exp %h", got, exp));
  endtask

  task automatic chk_num(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) fail($sformatf("count %0d not in %0d..%0d", got, lo, hi));
  endtask

  task automatic acc_rd(input tcc_acc_e s, output logic [7:0] d);
    @(negedge clk);
    sel = s;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic acc_wr(input tcc_acc_e s, input logic [7:0] d);
    @(negedge clk);
    sel = s;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // High byte always first so the low byte comes from the snapshot
  task automatic rd16(input tcc_acc_e hi, input tcc_acc_e lo, output logic [15:0] r);
    logic [7:0] h;
    logic [7:0] l;
    acc_rd(hi, h);
    acc_rd(lo, l);
    r = {h, l};
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk_bit(cmp_pin[0], 1'b0);
    acc_rd(ACC_CMP2_HI, b);
    chk_byte(b, 8'h80);
    acc_rd(ACC_NONE, b);
    chk_byte(b, 8'h00);
    acc_rd(ACC_CNT_HI, b);
    chk_byte(b, 8'hFF);
    halt = 1'b0;
    repeat (40) @(negedge clk);
    acc_rd(ACC_CNT_HI, b);
    acc_rd(ACC_CNT_LO, b);
    chk_byte(b, 8'hFC);
    chk_bit(ovf, 1'b1);
    ovf_ie = 1'b1;
    mask = 1'b1;
    @(negedge clk);
    chk_bit(irq, 1'b0);
    mask = 1'b0;
    @(negedge clk);
    chk_bit(irq, 1'b1);
    ovf_ie = 1'b0;
    acc_rd(ACC_STATUS, b);
    chk_bit(b[`TCC_SR_OVF_BIT], 1'b1);
    acc_rd(ACC_ALT_LO, b);
    chk_bit(ovf, 1'b1);
    acc_rd(ACC_CNT_LO, b);
    chk_bit(ovf, 1'b0);
    // Prescaler rates; the window is widened by one for halt latency
    for (int i = 0; i < 4; i++) begin
      halt = 1'b1;
      clk_sel = codes[i];
      acc_wr(i == 3 ? ACC_ALT_LO : ACC_CNT_LO, 8'h00);
      halt = 1'b0;
      repeat (64) @(negedge clk);
      halt = 1'b1;
      repeat (2) @(negedge clk);
      acc_rd(ACC_CNT_LO, b);
      rd16(ACC_ALT_HI, ACC_ALT_LO, v);
      chk_byte(b, v[7:0]);
      chk_num(int'(16'(v - `TCC_CNT_RELOAD)), 64 / divs[i] - 1, 64 / divs[i] + 1);
    end
    clk_sel = `TCC_CLK_EXT;
    halt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      ext_edge = e_sel[i];
      rd16(ACC_CNT_HI, ACC_CNT_LO, v);
      pins.ext_toggle();
      rd16(ACC_CNT_HI, ACC_CNT_LO, w);
      chk_word(w, 16'(v + e_inc[i]));
    end
    // Captures with the counter frozen so the copied value is known
    clk_sel = `TCC_CLK_DIV4;
    halt = 1'b1;
    acc_wr(ACC_CNT_LO, 8'h00);
    cap_ie = 1'b1;
    pins.cap_set(0, 1'b1);
    chk_bit(cap_flag[0], 1'b1);
    chk_bit(irq, 1'b1);
    mask = 1'b1;
    @(negedge clk);
    chk_bit(irq, 1'b0);
    mask = 1'b0;
    cap_ie = 1'b0;
    acc_rd(ACC_STATUS, b);
    acc_rd(ACC_CAP1_LO, b);
    chk_byte(b, 8'hFC);
    chk_bit(cap_flag[0], 1'b0);
    acc_rd(ACC_CAP1_HI, b);
    chk_byte(b, 8'hFF);
    pins.cap_set(0, 1'b0);
    halt = 1'b0;
    repeat (20) @(negedge clk);
    halt = 1'b1;
    pins.cap_set(0, 1'b1);
    chk_bit(cap_flag[0], 1'b0);
    acc_rd(ACC_CAP1_LO, b);
    chk_byte(b, 8'hFC);
    rd16(ACC_CNT_HI, ACC_CNT_LO, v);
    pins.cap_set(0, 1'b0);
    pins.cap_set(0, 1'b1);
    rd16(ACC_CAP1_HI, ACC_CAP1_LO, w);
    chk_word(w, v);
    acc_rd(ACC_STATUS, b);
    acc_rd(ACC_CAP1_LO, b);
    single_pulse_mode = 1'b1;
    pins.cap_set(0, 1'b0);
    pins.cap_set(0, 1'b1);
    chk_bit(cap_flag[0], 1'b0);
    pins.cap_set(1, 1'b1);
    chk_bit(cap_flag[1], 1'b0);
    pins.cap_set(1, 1'b0);
    chk_bit(cap_flag[1], 1'b1);
    single_pulse_mode = 1'b0;
    // Compare timing measured against the overflow edge, pin level alternating
    cmp_ie = 1'b1;
    for (int i = 0; i < 4; i++) begin
      halt = 1'b1;
      clk_sel = c_code[i];
      lvl = {1'b0, i[0]};
      acc_rd(ACC_STATUS, b);
      acc_wr(ACC_CMP1_HI, c_val[i][15:8]);
      acc_wr(ACC_CMP1_LO, c_val[i][7:0]);
      acc_wr(ACC_CNT_LO, 8'h00);
      chk_bit(cmp_flag[0], 1'b0);
      chk_bit(ovf, 1'b0);
      halt = 1'b0;
      t_ovf = -1;
      t_cmp = -1;
      for (int n = 0; n < 200 && (t_ovf < 0 || t_cmp < 0); n++) begin
        @(negedge clk);
        if (ovf === 1'b1 && t_ovf < 0) t_ovf = n;
        if (cmp_flag[0] === 1'b1 && t_cmp < 0) t_cmp = n;
      end
      if (t_ovf < 0 || t_cmp < 0) begin
        fail("flag never set");
        summarize();
      end
      chk_num(t_cmp - t_ovf, c_off[i], c_off[i]);
      chk_bit(cmp_pin[0], i[0]);
      chk_bit(cmp_oe[0], 1'b1);
      chk_bit(irq, 1'b1);
    end
    acc_rd(ACC_STATUS, b);
    acc_rd(ACC_CMP1_LO, b);
    chk_bit(cmp_flag[0], 1'b0);
    acc_wr(ACC_CMP1_HI, 8'h00);
    acc_wr(ACC_CNT_LO, 8'h00);
    repeat (120) @(negedge clk);
    chk_bit(cmp_flag[0], 1'b0);
    halt = 1'b1;
    for (int i = 0; i < 2; i++) begin
      pwm = i[0];
      lvl = {1'b0, i[0]};
      frc = 2'h1;
      @(negedge clk);
      frc = 2'h0;
      repeat (2) @(negedge clk);
      chk_bit(cmp_pin[0], 1'b0);
      chk_bit(cmp_flag[0], 1'b0);
    end
    pwm = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd16(ACC_CNT_HI, ACC_CNT_LO, v);
    chk_word(v, `TCC_CNT_RELOAD);
    rd16(ACC_CMP1_HI, ACC_CMP1_LO, v);
    chk_word(v, `TCC_CMP_RESET);
    chk_bit(cap_flag[0], 1'b0);
    summarize();
  end
endmodule

`default_nettype wire
